// [inc/ims_pkg.sv]
package ims_pkg;

  // Register word offsets on the plain port
  localparam logic [2:0] ADDR_BUF = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_STAT = 3'h2;
  localparam logic [2:0] ADDR_FLAG = 3'h3;
  localparam logic [2:0] ADDR_BAUD = 3'h4;

  // Control register two field positions
  localparam int CTL_START = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_STOP = 2;
  localparam int CTL_RECV = 3;
  localparam int CTL_ACKREQ = 4;
  localparam int CTL_ACKSEL = 5;
  localparam int CTL_ACK_RECEIVED_STATUS = 6;
  localparam int CTL_REQ_W = 5;

  // Status register field positions
  localparam int STAT_BFULL = 0;
  localparam int STAT_BGN = 3;
  localparam int STAT_HALT = 4;

  // Flag register field positions, write one to clear
  localparam int FLG_EVENT = 0;
  localparam int FLG_COLL = 1;
  localparam int FLG_WRITE_COLLISION_FLAG = 2;
  localparam int FLG_OVF = 3;

  // Values after reset
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Bit counts
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef struct packed {
    logic scl;
    logic sda;
  } ims_lines_t;

  typedef struct packed {
    logic ackSel;
    logic ackReq;
    logic rxReq;
    logic stopReq;
    logic rsReq;
    logic startReq;
  } ims_ctrl_t;

  typedef struct packed {
    logic ovf;
    logic write_collision_flag;
    logic coll;
    logic evt;
  } ims_flags_t;

  typedef enum logic [1:0] {
    OP_TX = 2'h0,
    OP_RX = 2'h1,
    OP_ACK = 2'h3
  } ims_op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h00,
    ST_SB_CNT = 5'h01,
    ST_SB_HOLD = 5'h03,
    ST_RS_SCLLO = 5'h02,
    ST_RS_SDAREL = 5'h06,
    ST_RS_SCLREL = 5'h07,
    ST_RS_HIGH = 5'h05,
    ST_RS_SDALO = 5'h04,
    ST_BIT_LOW = 5'h0c,
    ST_BIT_REL = 5'h0d,
    ST_BIT_HIGH = 5'h0f,
    ST_PS_SDALO = 5'h0e,
    ST_PS_CNT1 = 5'h0a,
    ST_PS_SCLREL = 5'h0b,
    ST_PS_CNT2 = 5'h09,
    ST_PS_WAITP = 5'h08,
    ST_PS_CNT3 = 5'h18
  } ims_state_t;

endpackage

// [hw/ims_master_seq.sv]
// Functional notes
// R1 - Buffer write during any active sequence is dropped and sets write collision.
// R2 - Low five request bits ignore writes until a pending Start completes.
// R3 - Start with both lines high loads baud counter for one period.
// R4 - Both lines still high at expiry: drive data low, set begin detect.
// R5 - Count one more period, clear start request, hold data low, stop counter.
// R6 - Lines low at start or clock low before data low: collision, idle.
// R7 - Restart pulls clock low, releases data one period, then releases clock.
// R8 - Both high one period, data low one period, clock low, request clears.
// R9 - Restart sets begin detect on bus start, event flag only after timeout.
// R10 - Restart requested while another event runs has no effect.
// R11 - Restart collision: data low as clock rises, or clock falls early.
// R12 - Idle buffer write sets full flag and clocks out bits, period low/high.
// R13 - Full flag clears after eight bits; data released for acknowledge.
// R14 - Ninth bit captured into ack status: low clears, high sets.
// R15 - After ninth clock set event flag, hold clock low, stop counter.
// R16 - Software clears write collision before the next transmission.
// R17 - Receive request ignored unless the port is idle.
// R18 - Receive toggles clock per counter rollover and shifts data in.
// R19 - After eighth fall: clear request, load buffer, set full and event.
// R20 - Reading the buffer after a receive clears the full flag.
// R21 - Byte completing while full flag still set sets receive overflow.
// R22 - Software acknowledges each received byte and ends with nack or Stop.
// R23 - Software waits for event after Start, clears it, then loads address.
// R24 - Counter halts while released clock reads low, reloads when it reads high.
// R25 - Ack drives selected value one period low, one period high, then clears.
// R26 - Stop: data low, clock high, data high, halt detect, event one period later.
// R27 - Event, collision and write collision flags stay set until cleared.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module ims_master_seq import ims_pkg::*; #(
  parameter int BAUD_W = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [2:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWr,
  input wire logic busRd,
  output logic [7:0] busRdData,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);

  if (BAUD_W < 1 || BAUD_W > 8) begin : g_bad_baud
    $error("BAUD_W must lie between 1 and 8");
  end

  ims_lines_t syncA_q;
  ims_lines_t line_q;
  ims_lines_t linePrev_q;
  ims_state_t state_q;
  ims_op_t op_q;
  ims_ctrl_t ctrl_q;
  ims_flags_t flags_q;
  logic [BAUD_W-1:0] baud_q;
  logic [BAUD_W-1:0] brgCnt_q;
  logic brgLoad_q;
  logic brgRun_q;
  logic brgTick;
  logic [7:0] buf_q;
  logic [7:0] shift_q;
  logic [3:0] bitIdx_q;
  logic bufFull_q;
  logic rxMode_q;
  logic ack_received_status_q;
  logic bgn_q;
  logic halt_q;
  logic evtSet_q;
  logic colSet_q;
  logic ovfSet_q;
  logic startSeen;
  logic stopSeen;
  logic bufWr;
  logic bufRd;
  logic ctrlWr;
  logic reqBusy;

  assign bufWr = busWr && (busAddr == ADDR_BUF);
  assign bufRd = busRd && (busAddr == ADDR_BUF);
  assign ctrlWr = busWr && (busAddr == ADDR_CTRL);
  assign reqBusy = (ctrl_q[CTL_REQ_W-1:0] != '0) || (state_q != ST_IDLE);
  assign startSeen = linePrev_q.sda && !line_q.sda && line_q.scl && linePrev_q.scl;
  assign stopSeen = !linePrev_q.sda && line_q.sda && line_q.scl && linePrev_q.scl;
  assign brgTick = brgRun_q && !brgLoad_q && (brgCnt_q == '0);

  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      syncA_q <= '1;
      line_q <= '1;
      linePrev_q <= '1;
    end else begin
      syncA_q <= '{scl: sclIn, sda: sdaIn};
      line_q <= syncA_q;
      linePrev_q <= line_q;
    end
  end

  // Baud counter
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      brgCnt_q <= '0;
    end else if (brgLoad_q) begin
      brgCnt_q <= baud_q; // [R3]
    end else if (brgRun_q && brgCnt_q != '0) begin
      brgCnt_q <= brgCnt_q - 1'b1;
    end
  end

  // Baud reload register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      baud_q <= BAUD_RST[BAUD_W-1:0];
    end else if (busWr && busAddr == ADDR_BAUD) begin
      baud_q <= busWrData[BAUD_W-1:0];
    end
  end

  // Bus start and stop monitor
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bgn_q <= 1'b0;
      halt_q <= 1'b0;
    end else if (startSeen || (state_q == ST_SB_CNT && brgTick && line_q.scl && line_q.sda)) begin
      bgn_q <= 1'b1; // [R4] [R9]
      halt_q <= 1'b0;
    end else if (stopSeen) begin
      halt_q <= 1'b1; // [R26]
      bgn_q <= 1'b0;
    end
  end

  // Sticky flags, set beats clear
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags_q <= '0;
    end else begin
      if (busWr && busAddr == ADDR_FLAG) begin
        flags_q <= flags_q & ~busWrData[3:0]; // [R27]
      end
      if (evtSet_q) begin
        flags_q.evt <= 1'b1;
      end
      if (colSet_q) begin
        flags_q.coll <= 1'b1;
      end
      if (ovfSet_q) begin
        flags_q.ovf <= 1'b1; // [R21]
      end
      if (bufWr && reqBusy) begin
        flags_q.write_collision_flag <= 1'b1; // [R1]
      end
    end
  end

  // Read port
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busRdData <= BYTE_RST;
    end else if (busRd) begin
      case (busAddr)
        ADDR_BUF: busRdData <= buf_q;
        ADDR_CTRL: busRdData <= {1'b0, ack_received_status_q, ctrl_q};
        ADDR_STAT: busRdData <= {3'h0, halt_q, bgn_q, 2'h0, bufFull_q};
        ADDR_FLAG: busRdData <= {4'h0, flags_q};
        ADDR_BAUD: busRdData <= 8'(baud_q);
        default: busRdData <= 8'h00;
      endcase
    end else begin
      busRdData <= 8'h00;
    end
  end

  // Open-drain drivers only ever pull low
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  // Master sequencer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      op_q <= OP_TX;
      ctrl_q <= '0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      brgLoad_q <= 1'b0;
      brgRun_q <= 1'b0;
      buf_q <= BYTE_RST;
      shift_q <= BYTE_RST;
      bitIdx_q <= 4'h0;
      bufFull_q <= 1'b0;
      rxMode_q <= 1'b0;
      ack_received_status_q <= 1'b0;
      evtSet_q <= 1'b0;
      colSet_q <= 1'b0;
      ovfSet_q <= 1'b0;
    end else begin
      brgLoad_q <= 1'b0;
      evtSet_q <= 1'b0;
      colSet_q <= 1'b0;
      ovfSet_q <= 1'b0;
      if (ctrlWr) begin
        ctrl_q.ackSel <= busWrData[CTL_ACKSEL];
        if (!reqBusy) begin
          // Only one request is taken, highest priority first
          if (busWrData[CTL_START]) begin
            ctrl_q.startReq <= 1'b1;
          end else if (busWrData[CTL_RESTART]) begin
            ctrl_q.rsReq <= 1'b1; // [R10]
          end else if (busWrData[CTL_STOP]) begin
            ctrl_q.stopReq <= 1'b1;
          end else if (busWrData[CTL_RECV]) begin
            ctrl_q.rxReq <= 1'b1; // [R17]
          end else if (busWrData[CTL_ACKREQ]) begin
            ctrl_q.ackReq <= 1'b1;
          end
        end // Busy or start pending: low bits dropped [R2]
      end
      if (bufRd && rxMode_q) begin
        bufFull_q <= 1'b0; // [R20]
      end
      case (state_q)
        ST_IDLE: begin
          brgRun_q <= 1'b0;
          if (bufWr && !reqBusy) begin
            buf_q <= busWrData;
            shift_q <= busWrData;
            bufFull_q <= 1'b1; // [R12]
            rxMode_q <= 1'b0;
            op_q <= OP_TX;
            bitIdx_q <= 4'h0;
            sclOe <= 1'b1;
            sdaOe <= ~busWrData[7];
            brgLoad_q <= 1'b1;
            brgRun_q <= 1'b1;
            state_q <= ST_BIT_LOW;
          end else if (ctrl_q.startReq) begin
            if (line_q.scl && line_q.sda && !sclOe && !sdaOe) begin
              brgLoad_q <= 1'b1; // [R3]
              brgRun_q <= 1'b1;
              state_q <= ST_SB_CNT;
            end else if (!line_q.scl || !line_q.sda) begin
              ctrl_q.startReq <= 1'b0; // [R6]
              colSet_q <= 1'b1;
              sclOe <= 1'b0;
              sdaOe <= 1'b0;
            end else begin
              sclOe <= 1'b0;
              sdaOe <= 1'b0;
            end
          end else if (ctrl_q.rsReq) begin
            sclOe <= 1'b1; // [R7]
            state_q <= ST_RS_SCLLO;
          end else if (ctrl_q.stopReq) begin
            sclOe <= 1'b1;
            sdaOe <= 1'b1; // [R26]
            state_q <= ST_PS_SDALO;
          end else if (ctrl_q.rxReq || ctrl_q.ackReq) begin
            op_q <= ctrl_q.rxReq ? OP_RX : OP_ACK;
            rxMode_q <= ctrl_q.rxReq ? 1'b1 : rxMode_q;
            bitIdx_q <= 4'h0;
            sclOe <= 1'b1;
            sdaOe <= ctrl_q.rxReq ? 1'b0 : ~ctrl_q.ackSel; // [R25]
            brgLoad_q <= 1'b1;
            brgRun_q <= 1'b1;
            state_q <= ST_BIT_LOW;
          end
        end
        ST_SB_CNT: begin
          if (!line_q.scl) begin
            ctrl_q.startReq <= 1'b0; // [R6]
            colSet_q <= 1'b1;
            brgRun_q <= 1'b0;
            state_q <= ST_IDLE;
          end else if (brgTick) begin
            if (line_q.sda) begin
              sdaOe <= 1'b1; // [R4]
              brgLoad_q <= 1'b1;
              state_q <= ST_SB_HOLD;
            end else begin
              ctrl_q.startReq <= 1'b0;
              colSet_q <= 1'b1;
              brgRun_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_SB_HOLD: begin
          if (brgTick) begin
            ctrl_q.startReq <= 1'b0; // [R5]
            evtSet_q <= 1'b1; // [R23]
            brgRun_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_RS_SCLLO: begin
          if (!line_q.scl) begin
            sdaOe <= 1'b0; // [R7]
            brgLoad_q <= 1'b1;
            brgRun_q <= 1'b1;
            state_q <= ST_RS_SDAREL;
          end
        end
        ST_RS_SDAREL: begin
          if (brgTick) begin
            brgRun_q <= 1'b0;
            if (line_q.sda) begin
              sclOe <= 1'b0; // [R7]
              state_q <= ST_RS_SCLREL;
            end else begin
              ctrl_q.rsReq <= 1'b0;
              colSet_q <= 1'b1;
              sclOe <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_RS_SCLREL: begin
          if (line_q.scl) begin
            if (!line_q.sda) begin
              ctrl_q.rsReq <= 1'b0; // [R11]
              colSet_q <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              brgLoad_q <= 1'b1; // [R24]
              brgRun_q <= 1'b1;
              state_q <= ST_RS_HIGH;
            end
          end
        end
        ST_RS_HIGH: begin
          if (!line_q.scl) begin
            ctrl_q.rsReq <= 1'b0; // [R11]
            colSet_q <= 1'b1;
            brgRun_q <= 1'b0;
            state_q <= ST_IDLE;
          end else if (brgTick) begin
            sdaOe <= 1'b1; // [R8]
            brgLoad_q <= 1'b1;
            state_q <= ST_RS_SDALO;
          end
        end
        ST_RS_SDALO: begin
          if (brgTick) begin
            sclOe <= 1'b1; // [R8]
            ctrl_q.rsReq <= 1'b0;
            evtSet_q <= 1'b1; // [R9]
            brgRun_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_BIT_LOW: begin
          if (brgTick) begin
            sclOe <= 1'b0; // [R12]
            brgRun_q <= 1'b0;
            state_q <= ST_BIT_REL;
          end
        end
        ST_BIT_REL: begin
          if (line_q.scl) begin
            brgLoad_q <= 1'b1; // [R24]
            brgRun_q <= 1'b1;
            if (op_q == OP_RX) begin
              shift_q <= {shift_q[6:0], line_q.sda}; // [R18]
            end
            if (op_q == OP_TX && bitIdx_q == ACK_BIT) begin
              ack_received_status_q <= line_q.sda; // [R14]
            end
            state_q <= ST_BIT_HIGH;
          end
        end
        ST_BIT_HIGH: begin
          if (brgTick) begin
            sclOe <= 1'b1;
            bitIdx_q <= bitIdx_q + 4'h1;
            if (op_q == OP_TX && bitIdx_q < ACK_BIT) begin
              shift_q <= {shift_q[6:0], 1'b0};
              sdaOe <= (bitIdx_q == LAST_DATA_BIT) ? 1'b0 : ~shift_q[6]; // [R13]
              if (bitIdx_q == LAST_DATA_BIT) begin
                bufFull_q <= 1'b0; // [R13]
              end
              brgLoad_q <= 1'b1;
              state_q <= ST_BIT_LOW;
            end else if (op_q == OP_RX && bitIdx_q < LAST_DATA_BIT) begin
              brgLoad_q <= 1'b1; // [R18]
              state_q <= ST_BIT_LOW;
            end else begin
              if (op_q == OP_RX) begin
                ctrl_q.rxReq <= 1'b0; // [R19]
                buf_q <= shift_q;
                bufFull_q <= 1'b1;
                ovfSet_q <= bufFull_q && !bufRd; // [R21]
              end
              if (op_q == OP_ACK) begin
                ctrl_q.ackReq <= 1'b0; // [R25]
              end
              evtSet_q <= 1'b1; // [R15] [R19]
              brgRun_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_PS_SDALO: begin
          if (!line_q.sda) begin
            brgLoad_q <= 1'b1; // [R26]
            brgRun_q <= 1'b1;
            state_q <= ST_PS_CNT1;
          end
        end
        ST_PS_CNT1: begin
          if (brgTick) begin
            sclOe <= 1'b0;
            brgRun_q <= 1'b0;
            state_q <= ST_PS_SCLREL;
          end
        end
        ST_PS_SCLREL: begin
          if (line_q.scl) begin
            brgLoad_q <= 1'b1; // [R24]
            brgRun_q <= 1'b1;
            state_q <= ST_PS_CNT2;
          end
        end
        ST_PS_CNT2: begin
          if (brgTick) begin
            sdaOe <= 1'b0; // [R26]
            brgRun_q <= 1'b0;
            state_q <= ST_PS_WAITP;
          end
        end
        ST_PS_WAITP: begin
          if (line_q.sda && line_q.scl) begin
            brgLoad_q <= 1'b1;
            brgRun_q <= 1'b1;
            state_q <= ST_PS_CNT3;
          end
        end
        ST_PS_CNT3: begin
          if (brgTick) begin
            ctrl_q.stopReq <= 1'b0; // [R26]
            evtSet_q <= 1'b1;
            brgRun_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          sclOe <= 1'b0;
          sdaOe <= 1'b0;
          brgRun_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// [sim/ims_seq_properties.sv]
`timescale 1ns/1ps
module ims_seq_props import ims_pkg::*; #(
  parameter int BAUD_W = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [2:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [7:0] busRdData,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  logic ctlWr;
  logic startWr;
  logic idleHi;
  assign ctlWr = busWr && busAddr == ADDR_CTRL;
  assign startWr = ctlWr && busWrData == 8'h01;
  assign idleHi = sclIn && sdaIn && !sclOe && !sdaOe;
  property p_start_wait;
    startWr && idleHi |=> (!sdaOe) [*2];
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("start drove data early");
  property p_start_drive;
    startWr && idleHi |-> ##[1:600] (sdaOe || !sclIn);
  endproperty
  a_start_drive: assert property (p_start_drive) else $error("start never drove data");
  property p_start_hold;
    $rose(sdaOe) && !sclOe |-> ##1 (sdaOe && !sclOe) [*2];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start hold too short");
  property p_start_coll;
    (!sclIn && !sclOe && !sdaOe) [*4] ##0 startWr |=> (!sdaOe && !sclOe) [*8];
  endproperty
  a_start_coll: assert property (p_start_coll) else $error("start drove a busy bus");
  property p_restart;
    sclOe [*8] ##0 (ctlWr && busWrData[CTL_RESTART]) |->
      ##[1:8] (sclOe && !sdaOe) ##[1:600] !sclOe;
  endproperty
  a_restart: assert property (p_restart) else $error("restart clock not released");
  property p_tx_go;
    (!sclOe && sdaOe) [*8] ##0 (busWr && busAddr == ADDR_BUF) |=> ##[0:2] sclOe;
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("transmit did not start");
  property p_scl_high;
    $rose(sclIn) && !sclOe |-> (!sclOe) [*4];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high time too short");
  property p_stop_end;
    $rose(sdaIn) && sclIn && !sclOe && !sdaOe |-> (!sdaOe && !sclOe) [*4];
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("bus not left free after stop");
endmodule

bind ims_master_seq ims_seq_props #(.BAUD_W(BAUD_W)) u_props (.clk_sys(clk_sys),
  .resetn(resetn), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
  .busRdData(busRdData), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe));

// [sim/ims_slave_model.sv]
`timescale 1ns/1ps
module ims_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_sequence_request,
  input wire logic rdMode,
  input wire logic [7:0] rdByte,
  input wire logic stretch,
  output logic sclLow,
  output logic sdaLow,
  output logic [7:0] gotByte,
  output logic lastBit
);
  int bitCnt_q = 0;
  logic [7:0] shift_q = 8'h00;
  initial begin
    gotByte = 8'h00;
    lastBit = 1'b1;
  end
  // Start or repeated start rearms the bit count
  // Settle first: data and clock may fall in one step
  always @(negedge sda) begin
    #1;
    if (scl && !sda) begin
      bitCnt_q = -1;
    end
  end
  always @(posedge scl) begin
    lastBit = sda;
    shift_q = {shift_q[6:0], sda};
  end
  always @(negedge scl) begin
    bitCnt_q = (bitCnt_q == 8) ? 0 : bitCnt_q + 1;
    if (bitCnt_q == 8) begin
      gotByte = shift_q;
    end
  end
  // Ack in ninth slot, else read data MSB first
  assign sdaLow = rdMode ? (bitCnt_q >= 0 && bitCnt_q < 8 && !rdByte[7 - bitCnt_q])
    : (ack_sequence_request && bitCnt_q == 8);
  assign sclLow = stretch;
endmodule

// [sim/ims_master_seq_tb_top.sv]
`timescale 1ns/1ps
module ims_master_seq_tb_top import ims_pkg::*; ;
  logic clk_sys, resetn, busWr, busRd, extScl, ack_sequence_request, rdMode, stretch;
  logic [2:0] busAddr;
  logic [7:0] busWrData, busRdData, rdByte, gotByte;
  logic sclOe, sdaOe, sclDrv, sdaDrv, slvScl, slvSda, lastBit, sclBus, sdaBus;
  int n_errors = 0;
  int checked = 0;
  assign sclBus = !(sclOe && !sclDrv) && !slvScl && !extScl;
  assign sdaBus = !(sdaOe && !sdaDrv) && !slvSda;
  ims_master_seq #(.BAUD_W(8)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .busAddr(busAddr),
    .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .sclIn(sclBus),
    .sclOut(sclDrv), .sclOe(sclOe), .sdaIn(sdaBus), .sdaOut(sdaDrv), .sdaOe(sdaOe));
  ims_slave_model u_slave (.scl(sclBus), .sda(sdaBus), .ack_sequence_request(ack_sequence_request), .rdMode(rdMode),
    .rdByte(rdByte), .stretch(stretch), .sclLow(slvScl), .sdaLow(slvSda), .gotByte(gotByte),
    .lastBit(lastBit));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busWr <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge clk_sys);
    busWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk_sys);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge clk_sys);
    busRd <= 1'b0;
    @(negedge clk_sys);
    chk(busRdData & mask, exp);
  endtask
  // Poll event flag, then clear it
  task automatic waitEvt();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      busRd <= 1'b1;
      busAddr <= ADDR_FLAG;
      @(posedge clk_sys);
      busRd <= 1'b0;
      @(negedge clk_sys);
      if (busRdData[FLG_EVENT] === 1'b1) break;
    end
    if (i == 400) begin
      n_errors++;
      $display("MISMATCH t=%0t event wait ran out", $time);
      results();
    end
    wr(ADDR_FLAG, 8'h01);
  endtask
  task automatic t_reset();
    for (int a = 0; a < 6; a++) begin
      rdChk(a[2:0], 8'hff, 8'h00);
    end
    wr(ADDR_BAUD, 8'h02);
    rdChk(ADDR_BAUD, 8'hff, 8'h02);
  endtask
  task automatic t_start();
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_BUF, 8'h3c);
    wr(ADDR_CTRL, 8'h04);
    rdChk(ADDR_CTRL, 8'h1f, 8'h01);
    waitEvt();
    rdChk(ADDR_STAT, 8'h08, 8'h08);
    chk({6'h00, sclOe, sdaOe}, 8'h01);
    rdChk(ADDR_FLAG, 8'hff, 8'h04);
    rdChk(ADDR_BUF, 8'hff, 8'h00);
    wr(ADDR_FLAG, 8'h04);
  endtask
  task automatic t_tx(input logic [7:0] b, input logic ack);
    ack_sequence_request <= ack;
    wr(ADDR_BUF, b);
    rdChk(ADDR_STAT, 8'h01, 8'h01);
    wr(ADDR_BUF, 8'hff);
    wr(ADDR_CTRL, 8'h0a);
    rdChk(ADDR_CTRL, 8'h0a, 8'h00);
    waitEvt();
    chk(gotByte, b);
    rdChk(ADDR_STAT, 8'h01, 8'h00);
    rdChk(ADDR_CTRL, 8'h40, ack ? 8'h00 : 8'h40);
    chk({7'h00, sclOe}, 8'h01);
    rdChk(ADDR_FLAG, 8'hff, 8'h04);
    wr(ADDR_FLAG, 8'h04);
  endtask
  task automatic t_restart();
    wr(ADDR_CTRL, 8'h02);
    waitEvt();
    rdChk(ADDR_STAT, 8'h08, 8'h08);
    rdChk(ADDR_CTRL, 8'h1f, 8'h00);
    chk({6'h00, sclOe, sdaOe}, 8'h03);
  endtask
  task automatic t_rx(input logic [7:0] b, input logic slow, input logic rdIt,
    input logic [7:0] ovf, input logic [7:0] ackCmd);
    rdByte <= b;
    rdMode <= 1'b1;
    ack_sequence_request <= 1'b0;
    wr(ADDR_CTRL, 8'h08);
    if (slow) begin
      repeat (12) @(negedge clk_sys);
      for (int i = 0; i < 50 && sclBus; i++) @(negedge clk_sys);
      chk({7'h00, sclBus}, 8'h00);
      stretch <= 1'b1;
      repeat (30) @(negedge clk_sys);
      stretch <= 1'b0;
    end
    waitEvt();
    rdMode <= 1'b0;
    rdChk(ADDR_CTRL, 8'h08, 8'h00);
    rdChk(ADDR_STAT, 8'h01, 8'h01);
    rdChk(ADDR_FLAG, 8'h08, ovf);
    if (rdIt) begin
      rdChk(ADDR_BUF, 8'hff, b);
      rdChk(ADDR_STAT, 8'h01, 8'h00);
    end
    wr(ADDR_CTRL, ackCmd);
    waitEvt();
    chk({7'h00, lastBit}, {7'h00, ackCmd[CTL_ACKSEL]});
  endtask
  task automatic t_stop();
    wr(ADDR_CTRL, 8'h04);
    waitEvt();
    rdChk(ADDR_STAT, 8'h10, 8'h10);
    rdChk(ADDR_CTRL, 8'h1f, 8'h00);
    chk({6'h00, sclOe, sdaOe}, 8'h00);
  endtask
  task automatic t_coll();
    extScl <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(ADDR_CTRL, 8'h01);
    repeat (20) @(posedge clk_sys);
    rdChk(ADDR_FLAG, 8'hff, 8'h02);
    rdChk(ADDR_CTRL, 8'h1f, 8'h00);
    chk({6'h00, sclOe, sdaOe}, 8'h00);
    extScl <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rdChk(ADDR_FLAG, 8'hff, 8'h02);
    wr(ADDR_FLAG, 8'h02);
    rdChk(ADDR_FLAG, 8'hff, 8'h00);
  endtask
  initial begin
    resetn = 1'b0;
    busWr = 1'b0;
    busRd = 1'b0;
    busAddr = 3'h0;
    busWrData = 8'h00;
    extScl = 1'b0;
    ack_sequence_request = 1'b1;
    rdMode = 1'b0;
    rdByte = 8'h00;
    stretch = 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_start();
    t_tx(8'ha4, 1'b1);
    t_tx(8'h5b, 1'b0);
    t_restart();
    t_tx(8'ha5, 1'b1);
    t_rx(8'h96, 1'b1, 1'b1, 8'h00, 8'h10);
    t_rx(8'h3a, 1'b0, 1'b0, 8'h00, 8'h10);
    t_rx(8'hc5, 1'b0, 1'b0, 8'h08, 8'h30);
    wr(ADDR_FLAG, 8'h08);
    t_stop();
    t_coll();
    results();
  end
endmodule
